/* tb/sbs_ctl_model.sv */
// Memory controller model driving the burst SRAM pins
`timescale 1ns/1ps
module sbs_ctl_model (
  input wire logic clk_sys,
  output logic [sbs_pkg::ADDR_W-3:0] addr_upper,
  output logic addr_bit_one,
  output logic addr_bit_zero,
  output logic [sbs_pkg::LANES-1:0] byte_lane_write_n,
  output logic write_enable_n,
  output logic advance_or_load,
  output logic clock_qualify_n,
  output logic select_first_n,
  output logic select_second,
  output logic select_third_n,
  output logic [sbs_pkg::DQ_W-1:0] dq_in,
  output logic [sbs_pkg::LANES-1:0] lane_parity_bits_in
);
  import sbs_pkg::*;
  logic [WORD_W-1:0] wd, p1;
  logic wopen, w1;
  wire sel = !select_first_n && select_second && !select_third_n;
  wire wnow = advance_or_load ? wopen : sel && !write_enable_n;
  initial begin
    {clock_qualify_n, advance_or_load, write_enable_n, select_first_n,
      select_second, select_third_n} = 6'h0d;
    {addr_upper, addr_bit_one, addr_bit_zero, byte_lane_write_n} = '0;
    {wd, p1, w1, wopen, lane_parity_bits_in, dq_in} = '0;
  end
  // Data follows two qualified edges late; released pins show the inverse
  // so a core that samples at the wrong edge picks up garbage
  always @(posedge clk_sys) begin
    if (!clock_qualify_n) begin
      if (!advance_or_load) wopen <= sel && !write_enable_n;
      w1 <= wnow;
      p1 <= wd;
      {lane_parity_bits_in, dq_in} <= w1 ? p1 : ~{lane_parity_bits_in, dq_in};
    end
  end
  task automatic put(input logic [5:0] c, input logic [ADDR_W-1:0] a,
      input logic [LANES-1:0] b, input logic [WORD_W-1:0] d);
    @(posedge clk_sys);
    {clock_qualify_n, advance_or_load, write_enable_n, select_first_n,
      select_second, select_third_n} <= c;
    {addr_upper, addr_bit_one, addr_bit_zero} <= a;
    byte_lane_write_n <= b;
    wd <= d;
  endtask : put
endmodule : sbs_ctl_model

/* tb/sbs_sram_core_assertions.sv */
// Concurrent checks on the burst SRAM core pins
`timescale 1ns/1ps
module sbs_sram_core_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic advance_or_load,
  input wire logic write_enable_n,
  input wire logic clock_qualify_n,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic output_enable_n,
  input wire logic [sbs_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [sbs_pkg::LANES-1:0] lane_parity_bits_out,
  input wire logic lane_parity_oe_n
);
  import sbs_pkg::*;
  wire q = !clock_qualify_n;
  wire sel = !select_first_n && select_second && !select_third_n;
  wire ld = q && !advance_or_load;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_oe_gates: assert property (output_enable_n |-> dq_oe_n)
    else $error("data pins driven with output enable high");
  a_lane_oe_pair: assert property (lane_parity_oe_n == dq_oe_n)
    else $error("parity drive differs from data drive");
  a_stall_data: assert property (clock_qualify_n |=>
    $stable(dq_out) && $stable(lane_parity_bits_out))
    else $error("read data moved on an ignored edge");
  a_stall_drive: assert property (clock_qualify_n ##1
    $stable(output_enable_n) |-> $stable(dq_oe_n))
    else $error("drive changed on an ignored edge");
  a_read_drive: assert property (ld && sel && write_enable_n
    ##1 q ##1 q |=> output_enable_n || !dq_oe_n)
    else $error("read data not driven two edges after load");
  a_write_float: assert property (ld && sel && !write_enable_n
    ##1 q ##1 q |=> dq_oe_n)
    else $error("data pins driven in write data cycle");
  a_desel_float: assert property (ld && !sel ##1 q ##1 q
    |=> dq_oe_n)
    else $error("data pins driven while deselected");
  a_burst_drive: assert property (ld && sel && write_enable_n
    ##1 q && advance_or_load ##1 q ##1 q |=> output_enable_n || !dq_oe_n)
    else $error("burst advance gave no read data");
  a_adv_closed: assert property (ld && !sel ##1 q && advance_or_load
    ##1 q ##1 q |=> dq_oe_n)
    else $error("advance without open burst drove data");
endmodule : sbs_sram_core_assertions

bind sbs_sram_core sbs_sram_core_assertions chk_u (.clk_sys, .rst,
  .advance_or_load, .write_enable_n, .clock_qualify_n, .select_first_n,
  .select_second, .select_third_n, .output_enable_n, .dq_out, .dq_oe_n,
  .lane_parity_bits_out, .lane_parity_oe_n);

/* tb/sync_burst_sram_pin_control_tb.sv */
// Random and directed test of the burst SRAM core with a pin-level model
`timescale 1ns/1ps
module sync_burst_sram_pin_control_tb;
  import sbs_pkg::*;
  logic clk_sys, rst, output_enable_n, burst_order_strap, dq_oe_n;
  logic addr_bit_one, addr_bit_zero, write_enable_n, advance_or_load;
  logic clock_qualify_n, select_first_n, select_second, select_third_n;
  logic lane_parity_oe_n, open_q, bwr, v1, v2, w1, w2, drv;
  logic [ADDR_W-3:0] addr_upper;
  logic [LANES-1:0] byte_lane_write_n, lane_parity_bits_in, b1, b2;
  logic [LANES-1:0] lane_parity_bits_out;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic [ADDR_W-1:0] base, a1, a2;
  logic [1:0] stp;
  logic [31:0] r;
  logic [WORD_W-1:0] exp_d;
  logic [WORD_W-1:0] mem [int];
  int seed = 18, mismatches = 0, total_checks = 0, k, ph;
  sbs_sram_core dut_u (.clk_sys, .rst, .addr_upper, .addr_bit_one,
    .addr_bit_zero, .byte_lane_write_n, .write_enable_n, .advance_or_load,
    .clock_qualify_n, .select_first_n, .select_second, .select_third_n,
    .output_enable_n, .burst_order_strap, .dq_in, .dq_out, .dq_oe_n,
    .lane_parity_bits_in, .lane_parity_bits_out, .lane_parity_oe_n);
  sbs_ctl_model ctl_u (.clk_sys, .addr_upper, .addr_bit_one, .addr_bit_zero,
    .byte_lane_write_n, .write_enable_n, .advance_or_load, .clock_qualify_n,
    .select_first_n, .select_second, .select_third_n, .dq_in,
    .lane_parity_bits_in);
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o,
      input logic [WORD_W-1:0] n, input logic [LANES-1:0] b);
    for (int i = 0; i < LANES; i++) begin
      if (!b[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
        o[32 + i] = n[32 + i];
      end
    end
    return o;
  endfunction : merge
  task automatic check(input logic [WORD_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Reference pipeline: op at a qualified edge completes two qualified later
  always @(posedge clk_sys) begin
    if (rst) begin
      {open_q, v1, v2, drv} = '0;
    end else if (!clock_qualify_n) begin
      if (v2 && w2) begin
        mem[a2] = merge(mem[a2], {lane_parity_bits_in, dq_in}, b2);
      end
      drv = v2 && !w2;
      if (drv) exp_d = mem[a2];
      {v2, w2, a2, b2} = {v1, w1, a1, b1};
      if (!advance_or_load) begin
        open_q = !select_first_n && select_second && !select_third_n;
        bwr = !write_enable_n;
        base = {addr_upper, addr_bit_one, addr_bit_zero};
        stp = 2'h0;
      end else if (open_q) stp = stp + 2'h1;
      {v1, w1, b1} = {open_q, bwr, byte_lane_write_n};
      a1 = {base[ADDR_W-1:2], burst_order_strap ? base[1:0] ^ stp :
        base[1:0] + stp};
    end
  end
  always @(negedge clk_sys) begin
    if (!rst) begin
      check({35'h0, dq_oe_n},
        {35'h0, !(drv && !output_enable_n)});
      check({35'h0, lane_parity_oe_n},
        {35'h0, !(drv && !output_enable_n)});
      if (drv) check({lane_parity_bits_out, dq_out}, exp_d);
    end
  end
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #50_000;
    mismatches++;
    stop_test;
  end
  initial begin
    {rst, output_enable_n, burst_order_strap} = 3'b110;
    for (ph = 0; ph < 2; ph++) begin
      rst <= 1'b1;
      burst_order_strap <= ph[0];
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      output_enable_n <= 1'b0;
      repeat (3) ctl_u.put(6'h0d, '0, '0, '0);
      for (k = 0; k < 8; k++) begin
        ctl_u.put({1'b0, k[1:0] != 2'h0, 4'b0010},
          {k[2] ? 15'h7fff : 15'h0000, 2'h0}, 4'h0, {k[3:0], $random(seed)});
      end
      $display("preload phase %0d done", ph);
      for (k = 0; k < 400; k++) begin
        r = $random(seed);
        ctl_u.put({r[3:0] == 4'h0, r[4], r[5], r[8:6] == 3'h0 ? r[11:9] :
          3'b010}, {r[14] ? 15'h7fff : 15'h0000, r[16:15]}, r[20:17],
          {r[24:21], $random(seed)});
        output_enable_n <= r[25] & r[26];
      end
      $display("random phase %0d done", ph);
    end
    stop_test;
  end
endmodule : sync_burst_sram_pin_control_tb

/* verilog/sbs_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sbs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } sbs_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  sbs_fifo_st_t s_q;
  sbs_fifo_st_t s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.wp[PW] == s_q.rp[PW]) ||
                    (s_q.wp[PW-1:0] != s_q.rp[PW-1:0]);
  assign out_valid = s_q.wp != s_q.rp;
  assign out_data = mem[s_q.rp[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; only the pointers define contents
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[s_q.wp[PW-1:0]] <= in_data;
    end
  end
endmodule : sbs_fifo

/* verilog/sbs_pkg.sv */
// Shared widths, reset values and state types for the burst SRAM pin logic
package sbs_pkg;
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W = LANE_DATA_W + 1;
  localparam int WORD_W = LANES * LANE_W;
  localparam int DQ_W = LANES * LANE_DATA_W;
  localparam int WORDS = 131072;
  localparam int BURST_W = 2;
  localparam int RD_FIFO_DEPTH = 16;
  localparam logic [WORD_W-1:0] DOUT_RST = 36'h0_0000_0000;
  localparam logic [BURST_W-1:0] STEP_RST = 2'h0;
  localparam logic [1:0] STRAP_RST = 2'h3;

  typedef struct packed {
    logic vld;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
  } sbs_op_t;

  localparam sbs_op_t OP_IDLE = '0;

  typedef struct packed {
    sbs_op_t op1;
    sbs_op_t op2;
    logic burst_vld;
    logic burst_wr;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] step;
    logic [1:0] strap;
    logic [WORD_W-1:0] dout;
    logic drv;
  } sbs_state_t;
endpackage : sbs_pkg

/* verilog/sbs_sram_core.sv */
// Pin-level control and storage of a pipelined burst SRAM
//
// Functional notes
// [RULE_01] Address pins sampled each edge select one of 128K words.
// [RULE_02] Two low address bits seed a two-bit burst counter.
// [RULE_03] Low byte lane selects gate lane writes, only with write enable low.
// [RULE_04] Write enable is sampled only on edges with clock qualify low.
// [RULE_05] Controller starts a write with write enable low; high is no write.
// [RULE_06] Advance high on a qualified edge steps the burst counter.
// [RULE_07] Advance low on a qualified edge loads a new start address.
// [RULE_08] Controller loads a fresh address after a deselect cycle.
// [RULE_09] Edges with clock qualify high are ignored entirely; the burst strap synchronizer still shifts on them.
// [RULE_10] Selected only when first and third selects low and second high.
// [RULE_11] Async output enable low lets data pins drive; high floats them.
// [RULE_12] Pins float in write data, first clock after deselect, deselect.
// [RULE_13] Clock qualify high stretches the previous cycle, holding state.
// [RULE_14] Burst strap low gives linear order; high or open gives interleaved.
// [RULE_15] Parity bits behave as data bits of their byte lane.
// [RULE_16] Burst wraps within four word positions in strap-selected order.
`timescale 1ns/1ps
module sbs_sram_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [sbs_pkg::ADDR_W-3:0] addr_upper,
  input wire logic addr_bit_one,
  input wire logic addr_bit_zero,
  input wire logic [sbs_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic write_enable_n,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic output_enable_n,
  input wire logic burst_order_strap,
  input wire logic [sbs_pkg::DQ_W-1:0] dq_in,
  output logic [sbs_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [sbs_pkg::LANES-1:0] lane_parity_bits_in,
  output logic [sbs_pkg::LANES-1:0] lane_parity_bits_out,
  output logic lane_parity_oe_n
);
  import sbs_pkg::*;

  logic [WORD_W-1:0] mem [WORDS];
  sbs_state_t s_q;
  sbs_state_t s_d;
  logic qual;
  logic selected;
  logic [ADDR_W-1:0] addr_in;
  logic [WORD_W-1:0] wr_word;
  logic [WORD_W-1:0] rd_word;
  logic mem_we;
  logic push;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic [BURST_W-1:0] next_step;
  logic [BURST_W-1:0] base_lo;

  assign qual = !clock_qualify_n; // see [RULE_09]
  // see [RULE_10]
  assign selected = !select_first_n && select_second && !select_third_n;
  // see [RULE_01] [RULE_02]
  assign addr_in = {addr_upper, addr_bit_one, addr_bit_zero};
  assign next_step = s_q.step + 1'b1;
  assign base_lo = s_q.base[BURST_W-1:0];

  // Gather lanes: each lane is eight data bits plus its parity bit
  always_comb begin
    wr_word = '0;
    for (int i = 0; i < LANES; i++) begin
      // see [RULE_15]
      wr_word[i*LANE_W +: LANE_W] =
        {lane_parity_bits_in[i], dq_in[i*LANE_DATA_W +: LANE_DATA_W]};
    end
  end

  // Read with forwarding: a write landing this edge to the same word
  // would otherwise be missed by a back-to-back read
  always_comb begin
    rd_word = mem[s_q.op1.addr];
    if (s_q.op2.vld && s_q.op2.wr && s_q.op2.addr == s_q.op1.addr) begin
      for (int i = 0; i < LANES; i++) begin
        if (s_q.op2.lanes[i]) begin
          rd_word[i*LANE_W +: LANE_W] = wr_word[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign push = qual && s_q.op1.vld && !s_q.op1.wr && fifo_in_ready;
  assign pop = qual && s_q.op2.vld && !s_q.op2.wr;
  // Write data arrives two qualified edges after its address
  assign mem_we = qual && s_q.op2.vld && s_q.op2.wr;

  sbs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(RD_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  always_comb begin
    s_d = s_q;
    s_d.strap = {s_q.strap[0], burst_order_strap};
    if (qual) begin // see [RULE_13]
      s_d.op2 = s_q.op1;
      if (!advance_or_load) begin // see [RULE_07]
        if (selected) begin
          s_d.base = addr_in;
          s_d.step = STEP_RST;
          s_d.burst_vld = 1'b1;
          s_d.burst_wr = !write_enable_n; // see [RULE_04]
          s_d.op1.vld = 1'b1;
          s_d.op1.wr = !write_enable_n;
          s_d.op1.addr = addr_in;
          // see [RULE_03]
          s_d.op1.lanes = write_enable_n ? '0 : ~byte_lane_write_n;
        end else begin
          s_d.burst_vld = 1'b0;
          s_d.op1 = OP_IDLE;
        end
      end else if (s_q.burst_vld) begin // see [RULE_06]
        s_d.step = next_step;
        s_d.op1.vld = 1'b1;
        s_d.op1.wr = s_q.burst_wr;
        s_d.op1.addr = s_q.base;
        // see [RULE_14] [RULE_16]
        s_d.op1.addr[BURST_W-1:0] = s_q.strap[1] ? (base_lo ^ next_step) :
                                    (base_lo + next_step);
        s_d.op1.lanes = s_q.burst_wr ? ~byte_lane_write_n : '0;
      end else begin
        // Advance with no open burst is treated as a deselect
        s_d.op1 = OP_IDLE;
      end
      // see [RULE_12]
      s_d.drv = pop && fifo_out_valid;
      if (pop && fifo_out_valid) begin
        s_d.dout = fifo_out_data;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.op1 <= OP_IDLE;
      s_q.op2 <= OP_IDLE;
      s_q.burst_vld <= 1'b0;
      s_q.burst_wr <= 1'b0;
      s_q.base <= '0;
      s_q.step <= STEP_RST;
      s_q.strap <= STRAP_RST;
      s_q.dout <= DOUT_RST;
      s_q.drv <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      for (int i = 0; i < LANES; i++) begin
        if (s_q.op2.lanes[i]) begin // see [RULE_03] [RULE_15]
          mem[s_q.op2.addr][i*LANE_W +: LANE_W] <=
            wr_word[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Output enable is asynchronous by nature, so it gates the drivers
  // directly instead of going through flops
  always_comb begin
    dq_out = '0;
    for (int i = 0; i < LANES; i++) begin
      dq_out[i*LANE_DATA_W +: LANE_DATA_W] =
        s_q.dout[i*LANE_W +: LANE_DATA_W];
      lane_parity_bits_out[i] = s_q.dout[i*LANE_W + LANE_DATA_W];
    end
  end

  assign dq_oe_n = !(s_q.drv && !output_enable_n); // see [RULE_11] [RULE_12]
  assign lane_parity_oe_n = dq_oe_n; // see [RULE_15]
endmodule : sbs_sram_core
